// >>> rtl/cdt_phy.sv
// cdt_phy: digital model of a CAN transceiver with dominant timeout guard
// assumes txd and bus_rx_lvl are synchronous to clk_sys; the bus wire is
// resolved outside from bus_drv_oe (wired-and of all node drivers)
`timescale 1ns/100ps
module cdt_phy
  import cdt_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = GUARD_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // controller side
  input wire logic txd,
  output logic rxd,
  // bus side: resolved differential state, 0 dominant
  input wire logic bus_rx_lvl,
  output logic bus_drv_oe,
  output logic bus_lvl,
  // status
  output logic dominant_timeout
);

  cdt_guard_if gi();

  logic txd_r;
  logic fall_r;
  logic rxd_r;
  logic oe_r;
  logic bus_lvl_r;
  logic timeout_r;
  logic drv_nxt;

  // ----------------------------------------------------------------
  // transmit input capture
  // ----------------------------------------------------------------
  // one register stage gives the edge detector a clean previous value
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txd_r <= RST_TXD_LVL;
      fall_r <= 1'b0;
    end else begin
      txd_r <= txd;
      fall_r <= (txd_r == LVL_RECESSIVE) && (txd == LVL_DOMINANT);
    end
  end

  assign gi.txd_lvl = txd_r;
  assign gi.fall = fall_r;

  cdt_dominant_timeout_guard #(
    .LIMIT(TIMEOUT_CYCLES)
  ) u_dominant_timeout_guard (
    .clk_sys(clk_sys),
    .rst(rst),
    .g(gi)
  );

  // ----------------------------------------------------------------
  // driver
  // ----------------------------------------------------------------
  // the guard output already lags txd_r by a cycle, so the trip lands one
  // cycle after the count reaches the limit; negligible against 1.2 ms
  assign drv_nxt = (txd_r == LVL_DOMINANT) && !gi.timed_out;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      oe_r <= 1'b0;
      bus_lvl_r <= LVL_RECESSIVE;
      timeout_r <= RST_TIMEOUT;
    end else begin
      oe_r <= drv_nxt;
      bus_lvl_r <= drv_nxt ? LVL_DOMINANT : LVL_RECESSIVE;
      timeout_r <= gi.timed_out;
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  // single stage keeps loop delay to three cycles, well under a 5 Mbps bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxd_r <= LVL_RECESSIVE;
    end else begin
      rxd_r <= bus_rx_lvl;
    end
  end

  assign rxd = rxd_r;
  assign bus_drv_oe = oe_r;
  assign bus_lvl = bus_lvl_r;
  assign dominant_timeout = timeout_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // observer of the dominant run, kept apart from the guard's own counter so
  // the trip point is judged from txd_r alone and not from the guard's state
  localparam int unsigned RUN_W = GUARD_CNT_W + 1;
  localparam logic [RUN_W-1:0] RUN_TRIP = RUN_W'(TIMEOUT_CYCLES + 1);
  localparam logic [RUN_W-1:0] RUN_SAT = RUN_W'(TIMEOUT_CYCLES + 2);

  logic [RUN_W-1:0] run_r;

  // saturates one past the trip point, so the trip compare matches only once
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      run_r <= '0;
    end else if (txd_r == LVL_RECESSIVE) begin
      run_r <= '0;
    end else if (run_r < RUN_SAT) begin
      run_r <= run_r + RUN_W'(1);
    end
  end

  sequence s_dom_held;
    (txd_r == LVL_DOMINANT) && !gi.timed_out;
  endsequence

  sequence s_tx_fall;
    (txd_r == LVL_RECESSIVE) && (txd == LVL_DOMINANT);
  endsequence

  sequence s_tx_rise;
    (txd_r == LVL_DOMINANT) && (txd == LVL_RECESSIVE);
  endsequence

  sequence s_driving;
    bus_drv_oe && (bus_lvl == LVL_DOMINANT);
  endsequence

  sequence s_released;
    !bus_drv_oe && (bus_lvl == LVL_RECESSIVE);
  endsequence

  // trip lands one edge after the run reaches the limit, the release one later
  sequence s_trip_release;
    gi.timed_out ##1 (!bus_drv_oe && (bus_lvl == LVL_RECESSIVE) && dominant_timeout);
  endsequence

  // reset values, checked without the disable so the reset itself is covered
  AST_RESET_STATE: assert property (@(posedge clk_sys)
    rst |=> (!bus_drv_oe && bus_lvl == LVL_RECESSIVE && !dominant_timeout && rxd == LVL_RECESSIVE))
    else $error("outputs not at reset values");

  // driver levels against bus_drv_oe and the registered transmit level
  AST_DOM_ONLY_DRIVEN: assert property (@(posedge clk_sys) disable iff (rst)
    (bus_lvl == LVL_DOMINANT) |-> bus_drv_oe)
    else $error("dominant level without driver");

  AST_REC_WHEN_IDLE: assert property (@(posedge clk_sys) disable iff (rst)
    (txd_r == LVL_RECESSIVE) |=> (!bus_drv_oe && bus_lvl == LVL_RECESSIVE))
    else $error("bus not recessive after recessive txd");

  AST_DRIVE_FOLLOWS: assert property (@(posedge clk_sys) disable iff (rst)
    s_dom_held |=> bus_drv_oe)
    else $error("driver not on for dominant txd");

  // pin to bus latency is two edges in both directions
  AST_TX_TO_BUS: assert property (@(posedge clk_sys) disable iff (rst)
    s_tx_fall |-> ##2 s_driving)
    else $error("dominant txd not on bus two cycles later");

  AST_TX_TO_REC: assert property (@(posedge clk_sys) disable iff (rst)
    s_tx_rise |-> ##2 s_released)
    else $error("recessive txd not on bus two cycles later");

  // edge pulse feeding the guard
  AST_FALL_IS_DOM: assert property (@(posedge clk_sys) disable iff (rst)
    fall_r |-> (txd_r == LVL_DOMINANT))
    else $error("falling edge pulse without dominant level");

  AST_FALL_PULSE: assert property (@(posedge clk_sys) disable iff (rst)
    fall_r |=> !fall_r)
    else $error("falling edge pulse longer than one cycle");

  // timeout: not early, not late, held until recessive
  AST_NO_EARLY_TRIP: assert property (@(posedge clk_sys) disable iff (rst)
    gi.timed_out |-> (run_r >= RUN_TRIP))
    else $error("guard tripped before the limit");

  AST_TRIP_SEQ: assert property (@(posedge clk_sys) disable iff (rst)
    (run_r == RUN_TRIP) |-> s_trip_release)
    else $error("guard trip or bus release missing at limit");

  AST_DRIVE_BOUNDED: assert property (@(posedge clk_sys) disable iff (rst)
    bus_drv_oe |-> (run_r <= RUN_TRIP))
    else $error("driver held on past the limit");

  AST_TIMEOUT_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    (gi.timed_out && txd_r == LVL_DOMINANT) |=> (gi.timed_out && dominant_timeout))
    else $error("timeout dropped while txd dominant");

  AST_TIMEOUT_RELEASE: assert property (@(posedge clk_sys) disable iff (rst)
    gi.timed_out |=> (!bus_drv_oe && dominant_timeout))
    else $error("bus not released during timeout");

  AST_RELEASE_RECOVER: assert property (@(posedge clk_sys) disable iff (rst)
    (dominant_timeout && txd_r == LVL_RECESSIVE) |-> ##2 !dominant_timeout)
    else $error("timeout not cleared by recessive txd");

  // receive path keeps working whether or not the guard has tripped
  AST_RX_FOLLOWS: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1 |=> rxd == $past(bus_rx_lvl))
    else $error("rxd does not follow bus");

  AST_RX_IN_TIMEOUT: assert property (@(posedge clk_sys) disable iff (rst)
    (dominant_timeout && bus_rx_lvl == LVL_DOMINANT) |=> (rxd == LVL_DOMINANT))
    else $error("rxd lost bus activity during timeout");

endmodule : cdt_phy

// >>> rtl/cdt_pkg.sv
// cdt_pkg: constants shared by the transceiver digital model
// assumes a 25 MHz system clock; times are given in their own units
package cdt_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned CLK_PERIOD_NS = 40;
  // dominant timeout window, in microseconds (1.2 ms .. 3.8 ms)
  localparam int unsigned GUARD_MIN_US = 1200;
  localparam int unsigned GUARD_MAX_US = 3800;
  // a trip anywhere inside the window is legal; the least time is used, rounded up
  localparam int unsigned GUARD_CYCLES = (GUARD_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GUARD_CNT_W = 16;
  // fastest data phase rate carried, bits per second
  localparam int unsigned MAX_RATE_BPS = 5000000;
  localparam int unsigned MIN_BIT_CYCLES = CLK_HZ / MAX_RATE_BPS;

  // ----------------------------------------------------------------
  // reset values and bus levels
  // ----------------------------------------------------------------
  localparam logic LVL_DOMINANT = 1'b0;
  localparam logic LVL_RECESSIVE = 1'b1;
  localparam logic RST_TXD_LVL = 1'b1;
  localparam logic RST_DRV_EN = 1'b1;
  localparam logic RST_TIMEOUT = 1'b0;

endpackage : cdt_pkg

// >>> rtl/cdt_guard_if.sv
// cdt_guard_if: carries the timeout guard's view between top and guard
// assumes both ends run on clk_sys
`timescale 1ns/100ps
interface cdt_guard_if;
  logic txd_lvl;   // registered transmit level
  logic fall;      // one-cycle falling edge pulse
  logic timed_out; // guard has tripped

  modport top (output txd_lvl, output fall, input timed_out);
  modport guard (input txd_lvl, input fall, output timed_out);
endinterface : cdt_guard_if

// >>> rtl/cdt_dominant_timeout_guard.sv
// cdt_dominant_timeout_guard: counts a held dominant transmit level
// assumes txd_lvl and fall come from registers in clk_sys domain
`timescale 1ns/100ps
module cdt_dominant_timeout_guard
  import cdt_pkg::*;
#(
  parameter int unsigned LIMIT = GUARD_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // link to the top
  cdt_guard_if.guard g
);

  logic [GUARD_CNT_W-1:0] cnt_r;
  logic timed_out_r;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // restarts on every falling edge, sits at zero while recessive
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (g.txd_lvl == LVL_RECESSIVE) begin
      cnt_r <= '0;
    end else if (g.fall) begin
      cnt_r <= GUARD_CNT_W'(1);
    end else if (cnt_r < GUARD_CNT_W'(LIMIT)) begin
      cnt_r <= cnt_r + GUARD_CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // trip flag
  // ----------------------------------------------------------------
  // saturating counter keeps the flag set until a recessive level
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timed_out_r <= RST_TIMEOUT;
    end else if (g.txd_lvl == LVL_RECESSIVE) begin
      timed_out_r <= 1'b0;
    end else if (cnt_r >= GUARD_CNT_W'(LIMIT)) begin
      timed_out_r <= 1'b1;
    end
  end

  assign g.timed_out = timed_out_r;

  AST_TRIP_AT_LIMIT: assert property (@(posedge clk_sys) disable iff (rst)
    (g.txd_lvl == LVL_DOMINANT && cnt_r >= GUARD_CNT_W'(LIMIT)) |=> timed_out_r)
    else $error("guard did not trip at limit");
  AST_FALL_RESTART: assert property (@(posedge clk_sys) disable iff (rst)
    (g.fall && g.txd_lvl == LVL_DOMINANT) |=> cnt_r == GUARD_CNT_W'(1))
    else $error("counter not restarted on falling edge");
  AST_CLEAR_ON_REC: assert property (@(posedge clk_sys) disable iff (rst)
    (g.txd_lvl == LVL_RECESSIVE) |=> (cnt_r == '0 && !timed_out_r))
    else $error("guard not cleared while recessive");

endmodule : cdt_dominant_timeout_guard

// >>> sim/cdt_bus_model.sv
// cdt_bus_model: wired-and bus seen by the transceiver's receiver
// assumes one other node may pull dominant via other_dom
`timescale 1ns/100ps
module cdt_bus_model
  import cdt_pkg::*;
(
  // drivers on the wire
  input wire logic bus_drv_oe,
  input wire logic other_dom,
  // resolved level
  output logic bus_rx_lvl
);
  // any active driver wins; with none the bias leaves the wire recessive
  assign bus_rx_lvl = (bus_drv_oe | other_dom) ? LVL_DOMINANT : LVL_RECESSIVE;
endmodule : cdt_bus_model

// >>> sim/tb.sv
// tb: self-checking bench for cdt_phy with a short timeout limit
// assumes cdt_bus_model resolves the wire from bus_drv_oe
`timescale 1ns/100ps
module tb;
  import cdt_pkg::*;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  localparam int unsigned LIM = 60; // short, yet above eleven bits at the top rate
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic txd = 1'b1;
  logic other_dom = 1'b0;
  logic rxd, bus_rx_lvl, bus_drv_oe, bus_lvl, dominant_timeout;
  int err_total = 0;
  int n_tests = 0;
  always #20 clk_sys = ~clk_sys;
  cdt_phy #(.TIMEOUT_CYCLES(LIM)) u_cdt_phy (.clk_sys(clk_sys), .rst(rst), .txd(txd), .rxd(rxd),
    .bus_rx_lvl(bus_rx_lvl), .bus_drv_oe(bus_drv_oe), .bus_lvl(bus_lvl), .dominant_timeout(dominant_timeout));
  cdt_bus_model u_cdt_bus_model (.bus_drv_oe(bus_drv_oe), .other_dom(other_dom), .bus_rx_lvl(bus_rx_lvl));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  // inputs change at the falling edge, away from sampling
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : step
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk("bus_drv_oe", 1'b0, bus_drv_oe);
    chk("bus_lvl", LVL_RECESSIVE, bus_lvl);
    chk("dominant_timeout", 1'b0, dominant_timeout);
    chk("rxd", LVL_RECESSIVE, rxd);
  endtask : t_reset
  // plain dominant bit out and back in
  task automatic t_follow;
    txd = LVL_DOMINANT;
    step(3);
    chk("bus_drv_oe", 1'b1, bus_drv_oe);
    chk("bus_lvl", LVL_DOMINANT, bus_lvl);
    chk("rxd", LVL_DOMINANT, rxd);
    txd = LVL_RECESSIVE;
    step(3);
    chk("bus_drv_oe", 1'b0, bus_drv_oe);
    chk("rxd", LVL_RECESSIVE, rxd);
  endtask : t_follow
  // a one-cycle recessive gap must restart the count, so no trip
  task automatic t_restart;
    txd = LVL_DOMINANT;
    step(LIM - 2);
    txd = LVL_RECESSIVE;
    step(1);
    txd = LVL_DOMINANT;
    step(LIM - 2);
    chk("dominant_timeout", 1'b0, dominant_timeout);
    chk("bus_drv_oe", 1'b1, bus_drv_oe);
    txd = LVL_RECESSIVE;
    step(3);
  endtask : t_restart
  // stuck dominant trips, rx still follows, recessive recovers
  task automatic t_timeout;
    txd = LVL_DOMINANT;
    step(LIM + 6);
    chk("dominant_timeout", 1'b1, dominant_timeout);
    chk("bus_drv_oe", 1'b0, bus_drv_oe);
    chk("bus_lvl", LVL_RECESSIVE, bus_lvl);
    other_dom = 1'b1;
    step(2);
    chk("rxd", LVL_DOMINANT, rxd);
    other_dom = 1'b0;
    step(2);
    chk("rxd", LVL_RECESSIVE, rxd);
    txd = LVL_RECESSIVE;
    step(4);
    chk("dominant_timeout", 1'b0, dominant_timeout);
    txd = LVL_DOMINANT;
    step(3);
    chk("bus_drv_oe", 1'b1, bus_drv_oe);
    txd = LVL_RECESSIVE;
    step(3);
  endtask : t_timeout
  // top data rate, eleven dominant bits in a row then a few toggles
  task automatic t_fast;
    logic [15:0] pat;
    pat = 16'h001a;
    for (int i = 15; i >= 0; i--) begin
      txd = pat[i];
      step(MIN_BIT_CYCLES);
      chk("bus_lvl", pat[i], bus_lvl);
      chk("rxd", pat[i], rxd);
    end
    chk("dominant_timeout", 1'b0, dominant_timeout);
    txd = LVL_RECESSIVE;
    step(3);
  endtask : t_fast
  // reset in mid-trip clears the guard; a held dominant drives again two edges after reset ends
  task automatic t_rst_mid;
    txd = LVL_DOMINANT;
    step(LIM + 6);
    chk("dominant_timeout", 1'b1, dominant_timeout);
    rst = 1'b1;
    step(2);
    chk("dominant_timeout", 1'b0, dominant_timeout);
    chk("bus_drv_oe", 1'b0, bus_drv_oe);
    rst = 1'b0;
    step(3);
    chk("bus_drv_oe", 1'b1, bus_drv_oe);
    chk("bus_lvl", LVL_DOMINANT, bus_lvl);
    txd = LVL_RECESSIVE;
    step(3);
  endtask : t_rst_mid
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    step(6);
    rst = 1'b0;
    step(1);
    t_reset();
    t_follow();
    t_restart();
    t_timeout();
    t_fast();
    t_rst_mid();
    test_done();
  end
  // whole run is under 500 cycles; 2000 leaves ample margin
  initial begin
    #(40 * 2000);
    err_total++;
    test_done();
  end
endmodule : tb
